//--- hdl/host_data_bus_direction_control.sv
module host_data_bus_direction_control
  import host_bus_dir_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic transparent_i,
  input wire logic host_sel_i,
  input wire logic host_rd_i,
  input wire logic [DATA_W-1:0] host_rdata_i,
  input wire engine_req_t engine_i,
  input wire logic [DATA_W-1:0] engine_int_rdata_i,
  input wire logic [DATA_W-1:0] host_data_lines_i,
  output logic [DATA_W-1:0] host_data_lines_o,
  output logic [DATA_W-1:0] host_data_lines_oe_o,
  output logic [DATA_W-1:0] rx_data_o,
  output logic rx_valid_o,
  output bus_owner_t owner_o
);

  logic [1:0] sel_sync_r;
  logic [1:0] rd_sync_r;
  logic [DATA_W-1:0] din_s1_r;
  logic [DATA_W-1:0] din_s2_r;
  logic [DATA_W-1:0] dout_r;
  logic [DATA_W-1:0] dout_nxt;
  logic drive_r;
  logic drive_nxt;
  logic [DATA_W-1:0] rx_r;
  logic [DATA_W-1:0] rx_nxt;
  logic rx_valid_r;
  logic rx_valid_nxt;
  bus_owner_t owner_r;
  bus_owner_t owner_nxt;

  // host select strobe, two flops from the pin
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel_sync_r <= 2'h0;
    end else begin
      sel_sync_r <= {sel_sync_r[0], host_sel_i};
    end
  end

  // host direction strobe, two flops from the pin
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_sync_r <= 2'h0;
    end else begin
      rd_sync_r <= {rd_sync_r[0], host_rd_i};
    end
  end

  // data pins, two flops before the receive path
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      din_s1_r <= DATA_RESET;
      din_s2_r <= DATA_RESET;
    end else begin
      din_s1_r <= host_data_lines_i;
      din_s2_r <= din_s1_r;
    end
  end

  // host strobe qualified by its direction
  function automatic logic strobe_kind(input logic act, input logic dir);
    return act & dir;
  endfunction : strobe_kind

  // engine request gated by mode, buffered mode blocks it
  function automatic logic eng_gate(input logic tr, input logic req);
    return tr & req;
  endfunction : eng_gate

  // one-hot owner for the winning access kind
  function automatic bus_owner_t owner_of(input logic hrd, input logic hwr,
      input logic eint, input logic ewr, input logic erd);
    bus_owner_t own;
    own = SRC_NONE;
    if (hrd || hwr) begin
      own = SRC_HOST;
    end else if (eint) begin
      own = SRC_ENGINE_INT;
    end else if (ewr || erd) begin
      own = SRC_ENGINE_EXT;
    end
    return own;
  endfunction : owner_of

  // outgoing word for the winning outward kind
  function automatic logic [DATA_W-1:0] pick_word(input logic hrd,
      input logic eint, input logic ewr, input logic [DATA_W-1:0] host_w,
      input logic [DATA_W-1:0] int_w, input logic [DATA_W-1:0] eng_w);
    logic [DATA_W-1:0] word;
    word = DATA_RESET;
    if (hrd) begin
      word = host_w;
    end else if (eint) begin
      word = int_w;
    end else if (ewr) begin
      word = eng_w;
    end
    return word;
  endfunction : pick_word

  // host strobes after the two sync flops
  wire logic host_act = sel_sync_r[1];
  wire logic host_rd = strobe_kind(host_act, rd_sync_r[1]);
  wire logic host_wr = strobe_kind(host_act, ~rd_sync_r[1]);

  // engine requests, blocked in buffered mode
  wire logic eng_int_rd = eng_gate(transparent_i, engine_i.int_rd);
  wire logic eng_int_wr = eng_gate(transparent_i, engine_i.int_wr);
  wire logic eng_ext_wr = eng_gate(transparent_i, engine_i.ext_wr);
  wire logic eng_ext_rd = eng_gate(transparent_i, engine_i.ext_rd);
  wire logic eng_int = eng_int_rd | eng_int_wr;

  // one winner per cycle: host rd, host wr, int, ext wr, ext rd
  wire logic win_hrd = host_rd;
  wire logic win_hwr = host_wr;
  wire logic win_int = ~host_act & eng_int;
  wire logic win_ewr = ~host_act & ~eng_int & eng_ext_wr;
  wire logic win_erd = ~host_act & ~eng_int & ~eng_ext_wr & eng_ext_rd;

  // word offered to internal ram traffic
  wire logic [DATA_W-1:0] int_word =
    eng_int_wr ? engine_i.wdata : engine_int_rdata_i;

  // outward drive only for outward kinds, released otherwise
  assign drive_nxt = win_hrd | win_int | win_ewr;
  assign dout_nxt = pick_word(win_hrd, win_int, win_ewr, host_rdata_i,
    int_word, engine_i.wdata);

  // inward kinds take the synced pin word
  assign rx_valid_nxt = win_hwr | win_erd;
  assign rx_nxt = rx_valid_nxt ? din_s2_r : rx_r;

  // owner code follows the winner
  assign owner_nxt = owner_of(win_hrd, win_hwr, win_int, win_ewr, win_erd);

  // outward drive enable, released at reset
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      drive_r <= 1'b0;
    end else begin
      drive_r <= drive_nxt;
    end
  end

  // outgoing word
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dout_r <= DATA_RESET;
    end else begin
      dout_r <= dout_nxt;
    end
  end

  // received word, held until the next receive
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_r <= DATA_RESET;
    end else begin
      rx_r <= rx_nxt;
    end
  end

  // receive strobe, one cycle per received word
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_valid_r <= 1'b0;
    end else begin
      rx_valid_r <= rx_valid_nxt;
    end
  end

  // current owner of the lines
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      owner_r <= SRC_NONE;
    end else begin
      owner_r <= owner_nxt;
    end
  end

  assign host_data_lines_o = dout_r;
  assign host_data_lines_oe_o = {DATA_W{drive_r}};
  assign rx_data_o = rx_r;
  assign rx_valid_o = rx_valid_r;
  assign owner_o = owner_r;

endmodule : host_data_bus_direction_control

//--- hdl/host_bus_dir_pkg.sv
package host_bus_dir_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned EXT_ADDR_W = 16; // up to 64k words outside
  localparam logic [15:0] DATA_RESET = 16'h0000;

  // access source codes, one-hot
  typedef enum logic [3:0] {
    SRC_NONE = 4'h1,
    SRC_HOST = 4'h2,
    SRC_ENGINE_INT = 4'h4,
    SRC_ENGINE_EXT = 4'h8
  } bus_owner_t;

  // host access request, sampled from pins
  typedef struct packed {
    logic sel;
    logic rd;
    logic [DATA_W-1:0] wdata;
  } host_req_t;

  // protocol engine access request, same clock
  typedef struct packed {
    logic int_rd;
    logic int_wr;
    logic ext_rd;
    logic ext_wr;
    logic [DATA_W-1:0] wdata;
  } engine_req_t;
endpackage : host_bus_dir_pkg

//--- tb/bus_dir_props.sv
module bus_dir_props
  import host_bus_dir_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic transparent_i,
  input wire engine_req_t engine_i,
  input wire logic [DATA_W-1:0] host_data_lines_o,
  input wire logic [DATA_W-1:0] host_data_lines_oe_o,
  input wire logic rx_valid_o,
  input wire bus_owner_t owner_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // drive summaries
  wire drv = &host_data_lines_oe_o;
  wire rel = host_data_lines_oe_o == '0;
  wire hst = owner_o == SRC_HOST;
  wire [3:0] kind = transparent_i ? engine_i[19:16] : 4'h0;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  property p_idle; owner_o == SRC_NONE |-> rel; endproperty
  a_idle: assert property (p_idle) else $error("idle drive");
  property p_word; drv || rel; endproperty
  a_word: assert property (p_word) else $error("split lanes");
  property p_ewr; kind == 4'h1 |=> hst ||
    drv && host_data_lines_o == $past(engine_i.wdata); endproperty
  a_ewr: assert property (p_ewr) else $error("ext write");
  property p_erd; kind == 4'h2 |=> hst || rel && rx_valid_o; endproperty
  a_erd: assert property (p_erd) else $error("ext read");
  property p_int; kind[3:2] != 0 |=> hst ||
    drv && owner_o == SRC_ENGINE_INT; endproperty
  a_int: assert property (p_int) else $error("int access");
  property p_buf; !transparent_i |=> hst || owner_o == SRC_NONE; endproperty
  a_buf: assert property (p_buf) else $error("buffered");
  property p_rx; rx_valid_o |-> rel; endproperty
  a_rx: assert property (p_rx) else $error("rx driving");
  property p_ext; owner_o == SRC_ENGINE_EXT |-> rx_valid_o != drv; endproperty
  a_ext: assert property (p_ext) else $error("ext dir");
endmodule : bus_dir_props
bind host_data_bus_direction_control bus_dir_props i_props (.*);

//--- tb/host_side_model.sv
module host_side_model
  import host_bus_dir_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic [DATA_W-1:0] dev_oe_i,
  input wire logic [DATA_W-1:0] dev_data_i,
  input wire logic drive_i,
  input wire logic [DATA_W-1:0] word_i,
  output wire logic [DATA_W-1:0] lines_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DATA_W-1:0] last_r;
  // wire level: device, then far side, else wandering
  assign lines_o = dev_oe_i[0] ? dev_data_i :
    drive_i ? word_i : ~last_r;
  always @(posedge core_clk_i) last_r <= lines_o;
endmodule : host_side_model

//--- tb/tb_host_data_bus_direction_control.sv
module tb_host_data_bus_direction_control;
  import host_bus_dir_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = 0, rst_i = 1, tr = 0, sel = 0, rd = 0, far = 0;
  logic [DATA_W-1:0] w = '0, lines, d_o, oe, rxd, qd[$], qr[$];
  logic rxv;
  bus_owner_t own;
  engine_req_t eng = '0;
  int errors = 0, n_compared = 0, cyc = 0;
  always #5 core_clk_i = ~core_clk_i;
  host_data_bus_direction_control i_dut (.core_clk_i, .rst_i,
    .transparent_i(tr), .host_sel_i(sel), .host_rd_i(rd),
    .host_rdata_i(w), .engine_i(eng), .engine_int_rdata_i(w),
    .host_data_lines_i(lines), .host_data_lines_o(d_o),
    .host_data_lines_oe_o(oe), .rx_data_o(rxd), .rx_valid_o(rxv),
    .owner_o(own));
  host_side_model i_far (.core_clk_i, .dev_oe_i(oe), .dev_data_i(d_o),
    .drive_i(far), .word_i(w), .lines_o(lines));
  task automatic chk(string n, logic [DATA_W-1:0] e, g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic chk_rx(logic [DATA_W-1:0] e, g);
    chk("rx", e, g);
  endtask : chk_rx
  task automatic give_verdict;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // one transfer: expectations noted first, then far word with host select, then engine request pulse
  task automatic op(logic t, logic [3:0] k, logic s, r,
    logic [DATA_W-1:0] d);
    if (s ? r : t && k != 4'h2 && k != 0) qd.push_back(d);
    if (s ? !r : t && k == 4'h2) qr.push_back(d);
    @(posedge core_clk_i);
    {tr, w, rd, sel} <= {t, d, r, s};
    far <= s ? !r : k == 4'h2;
    @(posedge core_clk_i);
    sel <= 0;
    @(posedge core_clk_i);
    eng <= {k, d};
    @(posedge core_clk_i);
    eng <= '0;
    repeat (4) @(posedge core_clk_i);
    far <= 0;
  endtask : op
  // watcher: each appearing result takes the oldest note
  always @(negedge core_clk_i) if (!rst_i) begin
    if (oe[0]) chk("drive", qd.size() ? qd.pop_front() : ~d_o, d_o);
    if (rxv) chk_rx(qr.size() ? qr.pop_front() : ~rxd, rxd);
  end
  // hang guard
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(91138));
    repeat (4) @(posedge core_clk_i);
    rst_i <= 0;
    for (int i = 0; i < 24; i++) begin
      op((i / 6) % 2, i % 6 < 4 ? 4'h1 << i % 6 : 4'h0, i % 6 > 3,
        i % 6 == 4, DATA_W'($urandom));
    end
    chk("pending", 0, DATA_W'(qd.size() + qr.size()));
    give_verdict();
  end
endmodule : tb_host_data_bus_direction_control
